// *** bench/radio_spi_port_assertions.sv ***
// Concurrent checks on the pins of the radio serial register port.
// Assumes it is bound to the port and the host keeps select high between frames.
`timescale 1ns/1ps
module radio_spi_port_checker (
  input wire         clock,
  input wire         rst_n,
  input wire         select_n_pin,
  input wire         serial_out,
  input wire         serial_out_oe,
  input wire         supply_stable,
  input wire         oscillator_stable,
  input wire         packet_end,
  input wire [7:0]   signal_strength_value,
  input wire         crc_enable,
  input wire         crc_match,
  input wire [6:0]   link_quality_estimate,
  input wire         flush_receive_queue_cmd,
  input wire         flush_transmit_queue_cmd,
  input wire         device_not_ready_flag,
  input wire         append_valid,
  input wire [7:0]   append_byte,
  input wire [375:0] config_flat
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_ready_when_stable: assert property (supply_stable && oscillator_stable |=> !device_not_ready_flag)
    else $error("not-ready flag high while stable");
  a_not_ready_held: assert property (!(supply_stable && oscillator_stable) |=> device_not_ready_flag)
    else $error("not-ready flag low while unstable");
  a_status_first_bit: assert property ($fell(select_n_pin) |-> ##[2:5] (serial_out_oe && serial_out == device_not_ready_flag))
    else $error("status byte did not open the frame");
  a_quiet_out_low: assert property (!serial_out_oe |-> !serial_out)
    else $error("data out driven while released");
  a_append_pair: assert property ($rose(append_valid) |-> ##1 append_valid ##1 !append_valid)
    else $error("appended bytes not a pair");
  a_append_strength: assert property (packet_end && !append_valid |=> append_valid && append_byte == $past(signal_strength_value))
    else $error("first appended byte wrong");
  a_append_quality: assert property (packet_end && !append_valid |=> ##1
    append_byte == {$past(crc_match, 2) || !$past(crc_enable, 2), $past(link_quality_estimate, 2)})
    else $error("second appended byte wrong");
  a_flush_one_cycle: assert property (flush_receive_queue_cmd || flush_transmit_queue_cmd |=>
    !flush_receive_queue_cmd && !flush_transmit_queue_cmd)
    else $error("flush strobe longer than a cycle");
  a_idle_no_effect: assert property (select_n_pin [*8] |-> $stable(config_flat) && !flush_receive_queue_cmd)
    else $error("change without a frame");

  c_append: cover property ($rose(append_valid));
  c_flush_rx: cover property (flush_receive_queue_cmd);
  c_flush_tx: cover property (flush_transmit_queue_cmd);
endmodule

bind radio_spi_port radio_spi_port_checker radio_spi_port_checker_inst (
  .clock, .rst_n, .select_n_pin, .serial_out, .serial_out_oe, .supply_stable,
  .oscillator_stable, .packet_end, .signal_strength_value, .crc_enable, .crc_match,
  .link_quality_estimate, .flush_receive_queue_cmd, .flush_transmit_queue_cmd,
  .device_not_ready_flag, .append_valid, .append_byte, .config_flat
);

// *** bench/radio_spi_port_tb.sv ***
// Self-checking bench for the radio serial register port.
// Assumes the host model drives the serial pins and the checker is bound.
`timescale 1ns/1ps
`include "radio_spi_map.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR %0t: got %h expected %h", $time, a, e); end end
module radio_spi_port_tb;
  logic        clock, rst_n, supply_stable, oscillator_stable, packet_end;
  logic        receive_queue_overrun, transmit_queue_underrun, crc_enable, crc_match;
  logic [2:0]  radio_mode;
  logic [3:0]  receive_queue_count, transmit_queue_free;
  logic [6:0]  link_quality_estimate;
  logic [7:0]  signal_strength_value;
  wire         serial_clock_pin, select_n_pin, serial_in_pin, serial_out, serial_out_oe;
  wire         flush_receive_queue_cmd, flush_transmit_queue_cmd, device_not_ready_flag;
  wire         append_valid;
  wire [7:0]   append_byte;
  wire [375:0] config_flat;
  int          bad_count, checks_done;
  int          rx_flushes, tx_flushes;

  // Strobes last one cycle inside a frame, so they are counted as they pass
  always @(posedge clock) begin
    if (flush_receive_queue_cmd) rx_flushes++;
    if (flush_transmit_queue_cmd) tx_flushes++;
  end

  radio_spi_port radio_spi_port_inst (
    .clock, .rst_n, .serial_clock_pin, .select_n_pin, .serial_in_pin, .serial_out,
    .serial_out_oe, .supply_stable, .oscillator_stable, .radio_mode, .receive_queue_count,
    .transmit_queue_free, .receive_queue_overrun, .transmit_queue_underrun, .packet_end,
    .signal_strength_value, .crc_enable, .crc_match, .link_quality_estimate,
    .flush_receive_queue_cmd, .flush_transmit_queue_cmd, .device_not_ready_flag,
    .append_valid, .append_byte, .config_flat
  );
  spi_host spi_host_inst (.serial_clock_pin, .select_n_pin, .serial_in_pin, .serial_out);

  task automatic frame(input logic [7:0] h, d, output logic [7:0] s, r);
    spi_host_inst.open_frame();
    spi_host_inst.xfer(h, s);
    spi_host_inst.xfer(d, r);
    spi_host_inst.close_frame();
  endtask

  task automatic t_ready();
    logic [7:0] s, r;
    frame(`HDR_SINGLE_READ, 8'h00, s, r);
    `CHK(s[7], 1'b1)
    @(negedge clock);
    oscillator_stable = 1'b1;
    repeat (2) @(negedge clock);
    frame(`HDR_SINGLE_READ, 8'h00, s, r);
    `CHK(s[7], 1'b0)
    `CHK(serial_out_oe, 1'b0)
  endtask

  task automatic t_modes();
    logic [7:0] s, r;
    for (int m = 0; m < 6; m++) begin
      @(negedge clock);
      radio_mode = m[2:0];
      receive_queue_count = 4'(m + 9);
      transmit_queue_free = 4'(6 - m);
      frame(`HDR_SINGLE_READ, 8'h00, s, r);
      `CHK(s, {1'b0, m[2:0], 4'(m + 9)})
      frame({2'b00, `ADDR_NO_REG}, 8'hff, s, r);
      `CHK(s, {1'b0, m[2:0], 4'(6 - m)})
    end
    `CHK(config_flat, 376'h0)
  endtask

  task automatic t_events();
    logic [7:0] s, r;
    @(negedge clock);
    radio_mode = `CODE_RX;
    receive_queue_overrun = 1'b1;
    @(negedge clock);
    receive_queue_overrun = 1'b0;
    transmit_queue_underrun = 1'b1;
    @(negedge clock);
    transmit_queue_underrun = 1'b0;
    frame(`HDR_SINGLE_READ, 8'h00, s, r);
    `CHK(s[6:4], `CODE_RX_OVERRUN)
    // Useful bytes would be drained here, before the flush
    frame({2'b00, `ADDR_FLUSH_RX}, {2'b00, `ADDR_NO_REG}, s, r);
    `CHK(rx_flushes, 1)
    frame(`HDR_SINGLE_READ, 8'h00, s, r);
    `CHK(s[6:4], `CODE_TX_UNDERRUN)
    frame({2'b00, `ADDR_FLUSH_TX}, {2'b00, `ADDR_NO_REG}, s, r);
    `CHK({rx_flushes, tx_flushes}, {32'd1, 32'd1})
    frame(`HDR_SINGLE_READ, 8'h00, s, r);
    `CHK(s[6:4], `CODE_RX)
  endtask

  task automatic t_regs();
    logic [7:0] s, r;
    logic [7:0] v [3] = '{8'ha1, 8'ha2, 8'ha3};
    frame(`HDR_SINGLE_WRITE, 8'h3c, s, r);
    frame(`HDR_SINGLE_READ, 8'h00, s, r);
    `CHK(r, 8'h3c)
    `CHK(config_flat[7:0], 8'h3c)
    // Burst runs off the top of the map into the empty slot
    spi_host_inst.open_frame();
    spi_host_inst.xfer(`HDR_BURST_WRITE | 8'h2d, s);
    for (int i = 0; i < 3; i++)
      spi_host_inst.xfer(v[i], r);
    spi_host_inst.close_frame();
    `CHK(config_flat[375:360], {v[1], v[0]})
    spi_host_inst.open_frame();
    spi_host_inst.xfer(`HDR_BURST_READ | 8'h2d, s);
    for (int i = 0; i < 3; i++) begin
      spi_host_inst.xfer(8'h00, r);
      `CHK(r, i < 2 ? v[i] : `UNMAPPED_READ)
    end
    spi_host_inst.close_frame();
  endtask

  task automatic t_append();
    logic [1:0] crc [3] = '{2'b11, 2'b10, 2'b00};
    for (int i = 0; i < 3; i++) begin
      @(negedge clock);
      {crc_enable, crc_match} = crc[i];
      signal_strength_value = 8'h80 + 8'(i);
      link_quality_estimate = 7'h41 + 7'(i);
      packet_end = 1'b1;
      @(negedge clock);
      packet_end = 1'b0;
      `CHK({append_valid, append_byte}, {1'b1, signal_strength_value})
      @(negedge clock);
      `CHK({append_valid, append_byte}, {1'b1, crc[i] != 2'b10, link_quality_estimate})
      @(negedge clock);
      `CHK(append_valid, 1'b0)
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    {rst_n, oscillator_stable, packet_end, receive_queue_overrun, transmit_queue_underrun,
     crc_enable, crc_match, radio_mode, receive_queue_count, transmit_queue_free,
     link_quality_estimate, signal_strength_value} = '0;
    supply_stable = 1'b1;
    // Synchronisers reset to idle levels, so two edges are enough
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    t_ready();
    t_modes();
    t_events();
    t_regs();
    t_append();
    wrap_up();
  end

  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
endmodule

// *** bench/spi_host.sv ***
// Host model: serial master of the register link, mode 0, msb first.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
module spi_host (
  output logic serial_clock_pin,
  output logic select_n_pin,
  output logic serial_in_pin,
  input  wire  serial_out
);
  initial begin
    serial_clock_pin = 1'b0;
    select_n_pin = 1'b1;
    serial_in_pin = 1'b0;
  end
  task automatic open_frame();
    #1 select_n_pin = 1'b0;
    #24;
  endtask
  // Short high phase leaves the device its turn-around after each fall
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serial_in_pin = tx[i];
      #24 serial_clock_pin = 1'b1;
      rx[i] = serial_out;
      #8 serial_clock_pin = 1'b0;
    end
  endtask
  // Released line shows the inverse so a stale bit cannot pass
  task automatic close_frame();
    #24 select_n_pin = 1'b1;
    serial_in_pin = ~serial_in_pin;
    #48;
  endtask
endmodule

// *** rtl/appended_status.v ***
// Forms the two status bytes placed after a received packet's payload.
// Assumes the receive queue writer accepts one byte per valid cycle.
`timescale 1ns/1ps
module appended_status (
  input  wire       clock,
  input  wire       rst_n,
  input  wire       packet_end,
  input  wire [7:0] signal_strength_value,
  input  wire       crc_enable,
  input  wire       crc_match,
  input  wire [6:0] link_quality_estimate,
  output reg        append_valid,
  output reg  [7:0] append_byte
);
  localparam IDLE_S   = 2'h0;
  localparam SECOND_S = 2'h1;

  reg [1:0] state_r;
  reg [7:0] second_r;

  always @(posedge clock) begin
    if (!rst_n) begin
      state_r      <= IDLE_S;
      second_r     <= 8'h00;
      append_valid <= 1'b0;
      append_byte  <= 8'h00;
    end else begin
      case (state_r)
        IDLE_S: begin
          append_valid <= packet_end;
          if (packet_end) begin
            append_byte <= signal_strength_value;
            // Disabled check counts as a pass
            second_r <= {crc_match | ~crc_enable,
                         link_quality_estimate};
            state_r  <= SECOND_S;
          end
        end
        SECOND_S: begin
          append_valid <= 1'b1;
          append_byte  <= second_r;
          state_r      <= IDLE_S;
        end
        default: begin
          append_valid <= 1'b0;
          state_r      <= IDLE_S;
        end
      endcase
    end
  end
endmodule

// *** rtl/pin_sync.v ***
// Two-flop synchroniser for pins from outside the clock domain.
// Assumes the receiving logic reads only sync_out.
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             clock,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] async_in,
  input  wire [WIDTH-1:0] reset_level,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_r;

  // Reset level is a tie-off constant at each instance
  always @(posedge clock) begin
    if (!rst_n) begin
      meta_r   <= reset_level;
      sync_out <= reset_level;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// *** rtl/radio_spi_map.vh ***
// Constants for the radio serial register port: header layout, status
// byte fields, state codes and the configuration register map.
// Assumes it is included by its bare name from the rtl folder.
`ifndef RADIO_SPI_MAP_VH
`define RADIO_SPI_MAP_VH

// Header byte: bit 7 read, bit 6 burst, bits 5:0 address
`define HDR_RW_BIT        7
`define HDR_BURST_BIT     6
`define HDR_SINGLE_WRITE  8'h00
`define HDR_BURST_WRITE   8'h40
`define HDR_SINGLE_READ   8'h80
`define HDR_BURST_READ    8'hc0

// Status byte fields
`define ST_READY_BIT      7
`define ST_STATE_MSB      6
`define ST_STATE_LSB      4
`define ST_COUNT_MSB      3
`define ST_COUNT_LSB      0

// Main state codes
`define CODE_IDLE         3'h0
`define CODE_RX           3'h1
`define CODE_TX           3'h2
`define CODE_FAST_TX      3'h3
`define CODE_CALIBRATE    3'h4
`define CODE_SETTLING     3'h5
`define CODE_RX_OVERRUN   3'h6
`define CODE_TX_UNDERRUN  3'h7

// Address map
`define CFG_FIRST         6'h00
`define CFG_LAST          6'h2e
`define CFG_COUNT         47
`define ADDR_NO_REG       6'h2f
`define ADDR_FLUSH_RX     6'h3a
`define ADDR_FLUSH_TX     6'h3b
`define CFG_RESET         8'h00
`define UNMAPPED_READ     8'h00

// Configuration register offsets
`define PIN2_OUTPUT_SELECT     6'h00
`define PIN1_OUTPUT_SELECT     6'h01
`define PIN0_OUTPUT_SELECT     6'h02
`define QUEUE_THRESHOLDS       6'h03
`define FRAME_MARKER_HIGH      6'h04
`define FRAME_MARKER_LOW       6'h05
`define PACKET_LENGTH_LIMIT    6'h06
`define PACKET_AUTOMATION_A    6'h07
`define PACKET_AUTOMATION_B    6'h08
`define NODE_MATCH_ID          6'h09
`define CHANNEL_INDEX          6'h0a
`define SYNTH_CONTROL_A        6'h0b
`define SYNTH_CONTROL_B        6'h0c
`define CARRIER_WORD_HIGH      6'h0d
`define CARRIER_WORD_MID       6'h0e
`define CARRIER_WORD_LOW       6'h0f
`define MODEM_SETUP_4          6'h10
`define MODEM_SETUP_3          6'h11
`define MODEM_SETUP_2          6'h12
`define MODEM_SETUP_1          6'h13
`define MODEM_SETUP_0          6'h14
`define FREQUENCY_DEVIATION    6'h15
`define RADIO_FSM_SETUP_2      6'h16
`define RADIO_FSM_SETUP_1      6'h17
`define RADIO_FSM_SETUP_0      6'h18
`define OFFSET_COMPENSATION    6'h19
`define BIT_SYNC_SETUP         6'h1a
`define GAIN_CONTROL_2         6'h1b
`define GAIN_CONTROL_1         6'h1c
`define GAIN_CONTROL_0         6'h1d
`define WAKE_TIMEOUT_HIGH      6'h1e
`define WAKE_TIMEOUT_LOW       6'h1f
`define WAKE_POLLING_CONTROL   6'h20
`define RECEIVE_FRONT_END      6'h21
`define TRANSMIT_FRONT_END     6'h22
`define SYNTH_CALIBRATION_3    6'h23
`define SYNTH_CALIBRATION_2    6'h24
`define SYNTH_CALIBRATION_1    6'h25
`define SYNTH_CALIBRATION_0    6'h26
`define RC_OSCILLATOR_SETUP_1  6'h27
`define RC_OSCILLATOR_SETUP_0  6'h28
`define SYNTH_CAL_TEST         6'h29
`define PRODUCTION_CHECK       6'h2a
`define GAIN_LOOP_CHECK        6'h2b
`define FACTORY_TUNING_2       6'h2c
`define FACTORY_TUNING_1       6'h2d
`define FACTORY_TUNING_0       6'h2e

`endif

// *** rtl/radio_spi_port.v ***
// Serial register port of the radio: status byte, configuration
// registers, flush strobes and the appended packet status bytes.
// Assumes a host as serial master in mode 0, most significant bit first,
// with its serial clock at least eight system clocks per period.
`timescale 1ns/1ps
`include "radio_spi_map.vh"

// How it works
// - Ready flag high until supply and oscillator stable
// - Status bits 6:4 carry main state code
// - Calibrate code 4, settling code 5
// - Idle may stand in for transitional codes
// - Overrun code 6 held until host flush
// - Underrun code 7, cleared by transmit flush
// - Bits 3:0 receive count or transmit free
// - First appended byte is signal strength
// - Appended bit 7 is CRC pass flag
// - Appended bits 6:0 are link quality
// - Addresses 0x00 to 0x2E are read/write registers
module radio_spi_port (
  input  wire         clock,
  input  wire         rst_n,
  input  wire         serial_clock_pin,
  input  wire         select_n_pin,
  input  wire         serial_in_pin,
  output reg          serial_out,
  output reg          serial_out_oe,
  input  wire         supply_stable,
  input  wire         oscillator_stable,
  input  wire [2:0]   radio_mode,
  input  wire [3:0]   receive_queue_count,
  input  wire [3:0]   transmit_queue_free,
  input  wire         receive_queue_overrun,
  input  wire         transmit_queue_underrun,
  input  wire         packet_end,
  input  wire [7:0]   signal_strength_value,
  input  wire         crc_enable,
  input  wire         crc_match,
  input  wire [6:0]   link_quality_estimate,
  output reg          flush_receive_queue_cmd,
  output reg          flush_transmit_queue_cmd,
  output reg          device_not_ready_flag,
  output wire         append_valid,
  output wire [7:0]   append_byte,
  output wire [375:0] config_flat
);
  localparam IDLE_S = 2'h0;
  localparam HDR_S  = 2'h1;
  localparam DATA_S = 2'h2;

  wire [2:0] pins_sync;
  wire       sclk_s;
  wire       sel_n_s;
  wire       sin_s;

  reg  [1:0] phase_r;
  reg  [2:0] bit_cnt_r;
  reg  [6:0] shift_in_r;
  reg        sclk_d_r;
  reg        sel_d_r;
  reg        read_r;
  reg        burst_r;
  reg  [5:0] addr_r;
  reg  [7:0] data_out_r;
  reg        rx_overrun_r;
  reg        tx_underrun_r;
  reg  [7:0] cfg_r [0:`CFG_COUNT-1];

  reg  [2:0] state_code;
  reg  [7:0] status_now;
  reg  [7:0] out_byte;
  reg  [7:0] in_byte;
  reg  [7:0] read_mux;
  reg  [5:0] read_addr;
  reg        hdr_read;

  wire sclk_rise;
  wire sclk_fall;
  wire sel_fall;
  wire sel_rise;
  wire byte_done;
  wire flush_rx_now;
  wire flush_tx_now;

  integer i;
  genvar  g;

  // Idle levels: clock low, select high, data low
  pin_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clock       (clock),
    .rst_n       (rst_n),
    .async_in    ({serial_clock_pin, select_n_pin, serial_in_pin}),
    .reset_level (3'h2),
    .sync_out    (pins_sync)
  );

  assign sclk_s  = pins_sync[2];
  assign sel_n_s = pins_sync[1];
  assign sin_s   = pins_sync[0];

  assign sclk_rise = sclk_s & ~sclk_d_r & ~sel_n_s;
  assign sclk_fall = ~sclk_s & sclk_d_r & ~sel_n_s;
  assign sel_fall  = ~sel_n_s & sel_d_r;
  assign sel_rise  = sel_n_s & ~sel_d_r;
  assign byte_done = sclk_rise && (bit_cnt_r == 3'h7);

  always @* begin
    in_byte = {shift_in_r, sin_s};
  end

  // Strobes only as single-access headers; burst forms stay unused
  assign flush_rx_now = byte_done && (phase_r == HDR_S) && !in_byte[`HDR_BURST_BIT]
                        && (in_byte[5:0] == `ADDR_FLUSH_RX);
  assign flush_tx_now = byte_done && (phase_r == HDR_S) && !in_byte[`HDR_BURST_BIT]
                        && (in_byte[5:0] == `ADDR_FLUSH_TX);

  // Fault codes outrank the live mode; overrun wins if both stand
  always @* begin
    if (rx_overrun_r) begin
      state_code = `CODE_RX_OVERRUN;
    end else if (tx_underrun_r) begin
      state_code = `CODE_TX_UNDERRUN;
    end else begin
      // Mode source may show idle during short transitions
      state_code = radio_mode;
    end
  end

  // Direction bit arrives first, so the count field can follow it
  always @* begin
    hdr_read = (phase_r == HDR_S && bit_cnt_r == 3'h0) ? sin_s : read_r;
    status_now = {device_not_ready_flag,
                  state_code,
                  hdr_read ? receive_queue_count
                           : transmit_queue_free};
  end

  // Write bytes answer with status again, read bytes with data
  always @* begin
    if (phase_r == DATA_S && read_r) begin
      out_byte = data_out_r;
    end else begin
      out_byte = status_now;
    end
  end

  always @* begin
    read_addr = (phase_r == HDR_S) ? in_byte[5:0] : addr_r + 6'h01;
    if (read_addr <= `CFG_LAST) begin
      read_mux = cfg_r[read_addr];
    end else begin
      // 0x2f and status space return a fixed filler
      read_mux = `UNMAPPED_READ;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      sclk_d_r <= 1'b0;
      sel_d_r  <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      sel_d_r  <= sel_n_s;
    end
  end

  // Flag follows both conditions live, so a later dropout shows too
  always @(posedge clock) begin
    if (!rst_n) begin
      device_not_ready_flag <= 1'b1;
    end else begin
      device_not_ready_flag <= ~(supply_stable & oscillator_stable);
    end
  end

  // Set wins over a flush in the same cycle
  always @(posedge clock) begin
    if (!rst_n) begin
      rx_overrun_r             <= 1'b0;
      tx_underrun_r            <= 1'b0;
      flush_receive_queue_cmd  <= 1'b0;
      flush_transmit_queue_cmd <= 1'b0;
    end else begin
      rx_overrun_r  <= receive_queue_overrun | (rx_overrun_r & ~flush_rx_now);
      tx_underrun_r <= transmit_queue_underrun | (tx_underrun_r & ~flush_tx_now);
      flush_receive_queue_cmd  <= flush_rx_now;
      flush_transmit_queue_cmd <= flush_tx_now;
    end
  end

  // Transaction sequencer
  always @(posedge clock) begin
    if (!rst_n) begin
      phase_r    <= IDLE_S;
      bit_cnt_r  <= 3'h0;
      shift_in_r <= 7'h00;
      read_r     <= 1'b0;
      burst_r    <= 1'b0;
      addr_r     <= 6'h00;
      data_out_r <= 8'h00;
    end else if (sel_n_s) begin
      // Deselect aborts any partial byte
      phase_r   <= IDLE_S;
      bit_cnt_r <= 3'h0;
    end else begin
      case (phase_r)
        IDLE_S: begin
          phase_r   <= HDR_S;
          bit_cnt_r <= 3'h0;
        end
        HDR_S: begin
          if (sclk_rise) begin
            shift_in_r <= in_byte[6:0];
            bit_cnt_r  <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h0) begin
              read_r <= sin_s;
            end
            if (byte_done) begin
              burst_r    <= in_byte[`HDR_BURST_BIT];
              addr_r     <= in_byte[5:0];
              data_out_r <= read_mux;
              phase_r    <= DATA_S;
            end
          end
        end
        DATA_S: begin
          if (sclk_rise) begin
            shift_in_r <= in_byte[6:0];
            bit_cnt_r  <= bit_cnt_r + 3'h1;
            if (byte_done) begin
              if (burst_r) begin
                // Burst walks upward; beyond the map reads filler
                addr_r     <= addr_r + 6'h01;
                data_out_r <= read_mux;
              end else begin
                // Single access: next byte is a fresh header
                phase_r <= HDR_S;
              end
            end
          end
        end
        default: begin
          phase_r <= IDLE_S;
        end
      endcase
    end
  end

  // Configuration store
  always @(posedge clock) begin
    if (!rst_n) begin
      for (i = 0; i < `CFG_COUNT; i = i + 1) begin
        cfg_r[i] <= `CFG_RESET;
      end
    end else if (byte_done && phase_r == DATA_S && !read_r
                 && addr_r <= `CFG_LAST) begin
      // Writes at 0x2f and above are dropped here
      cfg_r[addr_r] <= in_byte;
    end
  end

  // Output pin: bit 7 of status appears on the third clock after select falls
  always @(posedge clock) begin
    if (!rst_n) begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (sel_rise || sel_n_s) begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (sel_fall) begin
      serial_out    <= status_now[`ST_READY_BIT];
      serial_out_oe <= 1'b1;
    end else if (sclk_fall) begin
      serial_out    <= out_byte[~bit_cnt_r];
      serial_out_oe <= 1'b1;
    end
  end

  generate
    for (g = 0; g < `CFG_COUNT; g = g + 1) begin : cfg_out
      assign config_flat[g*8 +: 8] = cfg_r[g];
    end
  endgenerate

  appended_status u_appended_status (
    .clock                 (clock),
    .rst_n                 (rst_n),
    .packet_end            (packet_end),
    .signal_strength_value (signal_strength_value),
    .crc_enable            (crc_enable),
    .crc_match             (crc_match),
    .link_quality_estimate (link_quality_estimate),
    .append_valid          (append_valid),
    .append_byte           (append_byte)
  );
endmodule
